// File: hw/bbu_consts.svh
// register offsets, field positions, reset values and cycle counts
`ifndef BBU_CONSTS_SVH
`define BBU_CONSTS_SVH
`define BBU_ADR_CMD 9'h000
`define BBU_ADR_PC 9'h004
`define BBU_ADR_STATUS_REGISTER 9'h008
`define BBU_ADR_STAT 9'h00c
`define BBU_WIN_BIT 8
`define BBU_CMD_OP_MSB 4
`define BBU_CMD_OP_LSB 0
`define BBU_CMD_BIT_MSB 7
`define BBU_CMD_BIT_LSB 5
`define BBU_CMD_ADR_MSB 12
`define BBU_CMD_ADR_LSB 8
`define BBU_CMD_TWO_WORD 13
`define BBU_CMD_K_MSB 22
`define BBU_CMD_K_LSB 16
`define BBU_FLAG_C 3'h0
`define BBU_FLAG_Z 3'h1
`define BBU_FLAG_N 3'h2
`define BBU_FLAG_V 3'h3
`define BBU_FLAG_S 3'h4
`define BBU_FLAG_H 3'h5
`define BBU_FLAG_T 3'h6
`define BBU_FLAG_I 3'h7
`define BBU_PC_RST 16'h0000
`define BBU_STATUS_REGISTER_RST 8'h00
`define BBU_CYC_ONE 2'h1
`define BBU_CYC_TWO 2'h2
`define BBU_CYC_THREE 2'h3
`endif

// File: hw/bbu_pkg.sv
// types shared by the branch and bit-operation unit
package bbu_pkg;
	typedef enum logic [4:0]
	{
		op_skip_if_io_bit_one,
		op_branch_flag_set,
		op_branch_flag_clear,
		op_branch_equal,
		op_branch_not_equal,
		op_branch_carry_one,
		op_branch_carry_zero,
		op_branch_same_or_higher,
		op_branch_lower,
		op_branch_minus,
		op_branch_plus,
		op_branch_signed_ge,
		op_branch_signed_lt,
		op_branch_half_carry_one,
		op_branch_half_carry_zero,
		op_branch_transfer_one,
		op_branch_transfer_zero,
		op_branch_overflow_zero,
		op_branch_irq_enabled,
		op_branch_irq_disabled,
		op_io_bit_set_op,
		op_io_bit_clear_op,
		op_shift_left_logical,
		op_shift_right_logical,
		op_rotate_left_carry,
		op_rotate_right_carry,
		op_shift_right_arith,
		op_status_bit_set_op,
		op_status_bit_clear_op,
		op_reg_bit_to_transfer,
		op_transfer_to_reg_bit
	} bbu_op_t;
	typedef enum logic [1:0] {st_idle, st_read, st_exec, st_hold} bbu_state_t;
endpackage

// File: hw/bbu_if.sv
// interfaces between the unit and its register memory and shifter
`timescale 1ns/100ps
`default_nettype none
interface bbu_mem_if;
	logic [5:0] rd_addr;
	logic [7:0] rd_data;
	logic we;
	logic [5:0] wr_addr;
	logic [7:0] wr_data;
	modport host (output rd_addr, we, wr_addr, wr_data, input rd_data);
	modport mem (input rd_addr, we, wr_addr, wr_data, output rd_data);
endinterface

interface bbu_alu_if;
	bbu_pkg::bbu_op_t op;
	logic [7:0] opnd;
	logic cin;
	logic [7:0] res;
	logic cout;
	logic zero;
	logic neg;
	logic ovf;
	modport host (output op, opnd, cin, input res, cout, zero, neg, ovf);
	modport alu (input op, opnd, cin, output res, cout, zero, neg, ovf);
endinterface
`default_nettype wire

// File: hw/bbu_regmem.sv
// working and i/o register storage with a registered read port
`timescale 1ns/100ps
`default_nettype none
module bbu_regmem #(parameter int AW = 6, parameter int DW = 8)
(
	input wire logic clk,
	bbu_mem_if.mem port
);
	import bbu_pkg::*;
	logic [DW-1:0] cells [0:(1<<AW)-1];

	always_ff @(posedge clk)
	begin
		if (port.we)
			cells[port.wr_addr] <= port.wr_data;
	end

	always_ff @(posedge clk)
	begin
		port.rd_data <= cells[port.rd_addr];
	end
endmodule
`default_nettype wire

// File: hw/bbu_shift.sv
// shift and rotate datapath with its result flags
`timescale 1ns/100ps
`default_nettype none
module bbu_shift
(
	bbu_alu_if.alu port
);
	import bbu_pkg::*;

	always_comb
	begin
		port.res = port.opnd;
		port.cout = port.cin;
		case (port.op)
			op_shift_left_logical:
			begin
				port.res = {port.opnd[6:0], 1'b0};
				port.cout = port.opnd[7];
			end
			op_shift_right_logical:
			begin
				port.res = {1'b0, port.opnd[7:1]};
				port.cout = port.opnd[0];
			end
			op_rotate_left_carry:
			begin
				port.res = {port.opnd[6:0], port.cin};
				port.cout = port.opnd[7];
			end
			op_rotate_right_carry:
			begin
				port.res = {port.cin, port.opnd[7:1]};
				port.cout = port.opnd[0];
			end
			op_shift_right_arith:
			begin
				port.res = {port.opnd[7], port.opnd[7:1]};
				port.cout = port.opnd[0];
			end
			default:
			begin
				port.res = port.opnd;
				port.cout = port.cin;
			end
		endcase
		port.zero = (port.res == 8'h00);
		port.neg = port.res[7];
		port.ovf = port.res[7] ^ port.cout;
	end
endmodule
`default_nettype wire

// File: hw/bbu_top.sv
// branch, skip and bit-operation unit behind a classic wishbone slave
//
// Overview of operation
// - skip next instruction when i/o bit is one
// - generic flag branch tests status bit s
// - equal on zero one, not-equal on zero zero
// - carry branches taken on carry one or zero
// - minus on negative one, plus on zero
// - signed branches compare negative xor overflow
// - half-carry branches test half-carry flag
// - transfer branches test transfer flag, one/two cycles
// - overflow-clear branch changes no flags
// - interrupt-flag branches test i, change nothing
// - i/o bit set/clear keeps others, two cycles
// - logical shifts insert zero, update z c n v
// - rotates move carry in and out
// - arithmetic right shift keeps bit seven
// - status bit set or clear by s
// - bit store copies register bit into t
// - bit load copies t into register bit
//
// Register access over Wishbone and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "bbu_consts.svh"
module bbu_top
(
	input wire logic CLK_SYS,
	input wire logic ARST_N,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [8:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	output logic BUSY
);
	import bbu_pkg::*;

	bbu_mem_if mem_bus ();
	bbu_alu_if alu_bus ();

	bbu_state_t state;
	bbu_state_t next_state;
	bbu_op_t op;
	logic [2:0] bsel;
	logic [4:0] radr;
	logic two_word;
	logic [6:0] k;
	logic [15:0] pc;
	logic [7:0] status_register;
	logic taken;
	logic [1:0] cyc_used;
	logic [1:0] cyc_left;
	logic pend;
	logic [15:0] next_pc;
	logic [7:0] next_status_register;
	logic [1:0] next_cyc;
	logic next_taken;
	logic is_br;
	logic br_cond;
	logic wr_en;
	logic [7:0] wr_val;
	logic [31:0] next_dat;
	logic [15:0] k_ext;
	logic [7:0] bit_mask;
	logic [7:0] opnd;
	logic io_op;
	logic [5:0] fsm_idx;
	logic bus_ok;
	logic bus_wr;
	logic start;
	logic c;
	logic z;
	logic n;
	logic v;
	logic h;
	logic t;
	logic i;

	bbu_regmem #(.AW(6), .DW(8)) u_mem
	(
		.clk(CLK_SYS),
		.port(mem_bus.mem)
	);

	bbu_shift u_shift
	(
		.port(alu_bus.alu)
	);

	assign c = status_register[`BBU_FLAG_C];
	assign z = status_register[`BBU_FLAG_Z];
	assign n = status_register[`BBU_FLAG_N];
	assign v = status_register[`BBU_FLAG_V];
	assign h = status_register[`BBU_FLAG_H];
	assign t = status_register[`BBU_FLAG_T];
	assign i = status_register[`BBU_FLAG_I];
	assign k_ext = {{9{k[6]}}, k};
	assign bit_mask = 8'h01 << bsel;
	assign opnd = mem_bus.rd_data;
	assign io_op = (op == op_skip_if_io_bit_one) || (op == op_io_bit_set_op)
		|| (op == op_io_bit_clear_op);
	assign fsm_idx = {io_op, radr};

	// accesses to the status address are served while busy so software can poll; all else waits
	assign bus_ok = WB_CYC_I && WB_STB_I && !WB_ACK_O && !pend
		&& (state == st_idle || WB_ADR_I == `BBU_ADR_STAT);
	assign bus_wr = pend && WB_WE_I && WB_SEL_I[0];
	assign start = bus_wr && (WB_ADR_I == `BBU_ADR_CMD);

	assign mem_bus.rd_addr = (state == st_idle) ? WB_ADR_I[7:2] : fsm_idx;
	assign mem_bus.we = (state == st_exec) ? wr_en : (bus_wr && WB_ADR_I[`BBU_WIN_BIT]);
	assign mem_bus.wr_addr = (state == st_exec) ? fsm_idx : WB_ADR_I[7:2];
	assign mem_bus.wr_data = (state == st_exec) ? wr_val : WB_DAT_I[7:0];

	assign alu_bus.op = op;
	assign alu_bus.opnd = opnd;
	assign alu_bus.cin = c;

	always_comb
	begin
		is_br = (op >= op_branch_flag_set) && (op <= op_branch_irq_disabled);
		case (op)
			op_branch_flag_set: br_cond = status_register[bsel];
			op_branch_flag_clear: br_cond = !status_register[bsel];
			op_branch_equal: br_cond = z;
			op_branch_not_equal: br_cond = !z;
			op_branch_carry_one: br_cond = c;
			op_branch_lower: br_cond = c;
			op_branch_carry_zero: br_cond = !c;
			op_branch_same_or_higher: br_cond = !c;
			op_branch_minus: br_cond = n;
			op_branch_plus: br_cond = !n;
			op_branch_signed_ge: br_cond = !(n ^ v);
			op_branch_signed_lt: br_cond = n ^ v;
			op_branch_half_carry_one: br_cond = h;
			op_branch_half_carry_zero: br_cond = !h;
			op_branch_transfer_one: br_cond = t;
			op_branch_transfer_zero: br_cond = !t;
			op_branch_overflow_zero: br_cond = !v;
			op_branch_irq_enabled: br_cond = i;
			op_branch_irq_disabled: br_cond = !i;
			default: br_cond = 1'b0;
		endcase
	end

	always_comb
	begin
		next_pc = pc + 16'h0001;
		next_status_register = status_register;
		next_cyc = `BBU_CYC_ONE;
		next_taken = 1'b0;
		wr_en = 1'b0;
		wr_val = opnd;
		case (op)
			op_skip_if_io_bit_one:
			begin
				if (opnd[bsel])
				begin
					next_taken = 1'b1;
					next_pc = pc + (two_word ? 16'h0003 : 16'h0002);
					next_cyc = two_word ? `BBU_CYC_THREE : `BBU_CYC_TWO;
				end
			end
			op_io_bit_set_op, op_io_bit_clear_op:
			begin
				wr_en = 1'b1;
				wr_val = (op == op_io_bit_set_op) ? (opnd | bit_mask)
					: (opnd & ~bit_mask);
				next_cyc = `BBU_CYC_TWO;
			end
			op_shift_left_logical, op_shift_right_logical, op_rotate_left_carry,
				op_rotate_right_carry, op_shift_right_arith:
			begin
				wr_en = 1'b1;
				wr_val = alu_bus.res;
				next_status_register[`BBU_FLAG_C] = alu_bus.cout;
				next_status_register[`BBU_FLAG_Z] = alu_bus.zero;
				next_status_register[`BBU_FLAG_N] = alu_bus.neg;
				next_status_register[`BBU_FLAG_V] = alu_bus.ovf;
			end
			op_status_bit_set_op: next_status_register[bsel] = 1'b1;
			op_status_bit_clear_op: next_status_register[bsel] = 1'b0;
			op_reg_bit_to_transfer: next_status_register[`BBU_FLAG_T] = opnd[bsel];
			op_transfer_to_reg_bit:
			begin
				wr_en = 1'b1;
				wr_val = t ? (opnd | bit_mask) : (opnd & ~bit_mask);
			end
			default:
			begin
				next_status_register = status_register;
			end
		endcase
		// branches never touch the status register
		if (is_br && br_cond)
		begin
			next_taken = 1'b1;
			next_pc = pc + k_ext + 16'h0001;
			next_cyc = `BBU_CYC_TWO;
		end
	end

	always_comb
	begin
		case (state)
			st_idle: next_state = start ? st_read : st_idle;
			st_read: next_state = st_exec;
			st_exec: next_state = (next_cyc == `BBU_CYC_ONE) ? st_idle : st_hold;
			st_hold: next_state = (cyc_left == 2'h1) ? st_idle : st_hold;
			default: next_state = st_idle;
		endcase
	end

	always_comb
	begin
		next_dat = 32'h0000_0000;
		if (WB_ADR_I[`BBU_WIN_BIT])
			next_dat = {24'h00_0000, mem_bus.rd_data};
		else if (WB_ADR_I == `BBU_ADR_CMD)
			next_dat = {9'h000, k, 2'h0, two_word, radr, bsel, op};
		else if (WB_ADR_I == `BBU_ADR_PC)
			next_dat = {16'h0000, pc};
		else if (WB_ADR_I == `BBU_ADR_STATUS_REGISTER)
			next_dat = {24'h00_0000, status_register};
		else if (WB_ADR_I == `BBU_ADR_STAT)
			next_dat = {28'h000_0000, cyc_used, taken, BUSY};
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			pend <= 1'b0;
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end
		else
		begin
			pend <= bus_ok;
			WB_ACK_O <= pend;
			if (pend)
				WB_DAT_O <= next_dat;
		end
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			state <= st_idle;
			BUSY <= 1'b0;
			cyc_left <= 2'h0;
		end
		else
		begin
			state <= next_state;
			BUSY <= (next_state != st_idle);
			if (state == st_exec)
				cyc_left <= next_cyc - 2'h1;
			else if (state == st_hold)
				cyc_left <= cyc_left - 2'h1;
		end
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			op <= op_skip_if_io_bit_one;
			bsel <= 3'h0;
			radr <= 5'h00;
			two_word <= 1'b0;
			k <= 7'h00;
		end
		else if (start)
		begin
			op <= bbu_op_t'(WB_DAT_I[`BBU_CMD_OP_MSB:`BBU_CMD_OP_LSB]);
			bsel <= WB_DAT_I[`BBU_CMD_BIT_MSB:`BBU_CMD_BIT_LSB];
			radr <= WB_DAT_I[`BBU_CMD_ADR_MSB:`BBU_CMD_ADR_LSB];
			two_word <= WB_DAT_I[`BBU_CMD_TWO_WORD];
			k <= WB_DAT_I[`BBU_CMD_K_MSB:`BBU_CMD_K_LSB];
		end
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
			pc <= `BBU_PC_RST;
		else if (bus_wr && WB_ADR_I == `BBU_ADR_PC)
			pc <= {WB_SEL_I[1] ? WB_DAT_I[15:8] : pc[15:8], WB_DAT_I[7:0]};
		else if (state == st_exec)
			pc <= next_pc;
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
			status_register <= `BBU_STATUS_REGISTER_RST;
		else if (bus_wr && WB_ADR_I == `BBU_ADR_STATUS_REGISTER)
			status_register <= WB_DAT_I[7:0];
		else if (state == st_exec)
			status_register <= next_status_register;
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			taken <= 1'b0;
			cyc_used <= 2'h0;
		end
		else if (state == st_exec)
		begin
			taken <= next_taken;
			cyc_used <= next_cyc;
		end
	end

	sequence s_exec_op(bbu_op_t o);
		state == st_exec && op == o;
	endsequence

	sequence s_hold_then_idle;
		state == st_hold ##1 state == st_idle;
	endsequence

	a_skip_target: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		s_exec_op(op_skip_if_io_bit_one) |=> pc == $past(pc)
			+ (!$past(opnd[bsel]) ? 16'h0001 : ($past(two_word) ? 16'h0003 : 16'h0002)))
		else $error("skip target wrong");

	a_skip_length: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		s_exec_op(op_skip_if_io_bit_one) ##0 (opnd[bsel] && two_word)
			|=> state == st_hold [*2] ##1 state == st_idle)
		else $error("long skip not three cycles");

	a_branch_target: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		(state == st_exec && is_br && br_cond)
			|=> pc == $past(pc) + $past(k_ext) + 16'h0001 ##0 s_hold_then_idle)
		else $error("taken branch target or length wrong");

	a_branch_miss: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		(state == st_exec && is_br && !br_cond) |=> pc == $past(pc) + 16'h0001
			&& state == st_idle)
		else $error("untaken branch not one cycle");

	a_generic_flag: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		s_exec_op(op_branch_flag_clear) |=> (state == st_hold) == !$past(status_register[bsel]))
		else $error("flag-clear branch decision wrong");

	a_equal_cond: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		(state == st_exec && (op == op_branch_equal || op == op_branch_not_equal))
			|=> (state == st_hold) == ($past(z) == $past(op == op_branch_equal)))
		else $error("equal branch decision wrong");

	a_carry_cond: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		(s_exec_op(op_branch_lower) or s_exec_op(op_branch_same_or_higher))
			|=> (state == st_hold) == ($past(c) == $past(op == op_branch_lower)))
		else $error("carry branch decision wrong");

	a_minus_cond: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		s_exec_op(op_branch_plus) |=> (state == st_hold) == !$past(n))
		else $error("plus branch decision wrong");

	a_signed_cond: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		s_exec_op(op_branch_signed_lt) |=> (state == st_hold) == $past(n ^ v))
		else $error("signed branch decision wrong");

	a_half_cond: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		s_exec_op(op_branch_half_carry_one) |=> (state == st_hold) == $past(h))
		else $error("half-carry branch decision wrong");

	a_transfer_cond: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		s_exec_op(op_branch_transfer_zero) |=> (state == st_hold) == !$past(t))
		else $error("transfer branch decision wrong");

	a_branch_flags: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		(state == st_exec && is_br)
			|=> status_register == $past(status_register) && !$past(mem_bus.we))
		else $error("branch altered flags");

	a_irq_cond: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		s_exec_op(op_branch_irq_enabled) |=> (state == st_hold) == $past(i))
		else $error("interrupt-flag branch decision wrong");

	a_io_bit_only: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		s_exec_op(op_io_bit_clear_op) |-> mem_bus.we && mem_bus.wr_data == (opnd & ~bit_mask)
			##1 status_register == $past(status_register) ##0 s_hold_then_idle)
		else $error("i/o bit clear wrong");

	a_shift_left: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		s_exec_op(op_shift_left_logical) |-> mem_bus.wr_data == {opnd[6:0], 1'b0}
			##1 c == $past(opnd[7]) && v == (n ^ c) && state == st_idle)
		else $error("left shift wrong");

	a_rotate_carry: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		s_exec_op(op_rotate_right_carry) |=> c == $past(opnd[0])
			&& $past(mem_bus.wr_data[7]) == $past(c))
		else $error("rotate carry wrong");

	a_arith_msb: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		s_exec_op(op_shift_right_arith) |-> mem_bus.wr_data == {opnd[7], opnd[7:1]})
		else $error("arithmetic shift lost sign");

	a_flag_write: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		s_exec_op(op_status_bit_set_op) |=> status_register[$past(bsel)] && state == st_idle)
		else $error("status bit not set");

	a_bit_store: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		s_exec_op(op_reg_bit_to_transfer) |=> t == $past(opnd[bsel]))
		else $error("bit store wrong");

	a_bit_load: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		s_exec_op(op_transfer_to_reg_bit) |-> mem_bus.wr_data[bsel] == t
			##1 status_register == $past(status_register))
		else $error("bit load wrong");
endmodule
`default_nettype wire

// File: sim/bbu_top_bench.sv
// self-checking bench for the branch, skip and bit-operation unit
`timescale 1ns/100ps
`default_nettype none
`include "bbu_consts.svh"
module bbu_top_bench;
	import bbu_pkg::*;
	logic clk_sys;
	logic arst_n;
	logic cyc;
	logic stb;
	logic we;
	logic [3:0] sel;
	logic [8:0] adr;
	logic [31:0] dat_w;
	logic [31:0] dat_r;
	logic ack;
	logic busy;
	int bad_count;
	int tests_run;
	int cycles = 0;
	logic [31:0] rd;
	logic [15:0] pc0;
	logic [15:0] pc_exp;
	logic [7:0] sr0;
	logic [7:0] sr_exp;
	logic [7:0] v;
	logic [8:0] sh;
	logic [6:0] k;
	logic tk;

	bbu_top bbu_top_i
	(
		.CLK_SYS(clk_sys),
		.ARST_N(arst_n),
		.WB_CYC_I(cyc),
		.WB_STB_I(stb),
		.WB_WE_I(we),
		.WB_SEL_I(sel),
		.WB_ADR_I(adr),
		.WB_DAT_I(dat_w),
		.WB_DAT_O(dat_r),
		.WB_ACK_O(ack),
		.BUSY(busy)
	);

	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// the whole run needs well under 10000 cycles; a hung handshake ends here
	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			bad_count = bad_count + 1;
			end_sim();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		tests_run = tests_run + 1;
		if (seen !== exp)
		begin
			bad_count = bad_count + 1;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	// one classic cycle; request held until ack is sampled, then released
	task automatic wb_cycle(input logic wr, input logic [8:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= a;
		dat_w <= d;
		sel <= s;
		do
			@(posedge clk_sys);
		while (ack !== 1'b1);
		rd = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic wb_rd(input logic [8:0] a);
		wb_cycle(1'b0, a, 32'h0, 4'hf);
	endtask

	task automatic prep(input logic [15:0] pc, input logic [7:0] sr);
		wb_cycle(1'b1, `BBU_ADR_PC, {16'h0, pc}, 4'h3);
		wb_cycle(1'b1, `BBU_ADR_STATUS_REGISTER, {24'h0, sr}, 4'h1);
	endtask

	task automatic post(input logic [15:0] pc, input logic [7:0] sr);
		wb_rd(`BBU_ADR_PC);
		check(rd, {16'h0, pc}, "program counter");
		wb_rd(`BBU_ADR_STATUS_REGISTER);
		check(rd, {24'h0, sr}, "status register");
	endtask

	// busy is sampled high from the ack edge on: n + 1 samples in all
	task automatic run_op(input logic [4:0] op, input logic [2:0] b, input logic [4:0] idx,
		input logic two, input logic [6:0] kk, input logic [1:0] n, input logic t);
		int hi;
		hi = 0;
		wb_cycle(1'b1, `BBU_ADR_CMD, {9'h000, kk, 2'b00, two, idx, b, op}, 4'hf);
		while (busy === 1'b1)
		begin
			hi = hi + 1;
			@(posedge clk_sys);
		end
		check(32'(hi), 32'(n) + 32'h1, "busy length");
		wb_rd(`BBU_ADR_STAT);
		check({29'h0, rd[3:1]}, {29'h0, n, t}, "cycles and taken");
	endtask

	function automatic logic cond(input logic [4:0] op, input logic [2:0] s, input logic [7:0] f);
		case (op)
			5'd1: return f[s];
			5'd2: return !f[s];
			5'd3: return f[1];
			5'd4: return !f[1];
			5'd5, 5'd8: return f[0];
			5'd6, 5'd7: return !f[0];
			5'd9: return f[2];
			5'd10: return !f[2];
			5'd11: return !(f[2] ^ f[3]);
			5'd12: return f[2] ^ f[3];
			5'd13: return f[5];
			5'd14: return !f[5];
			5'd15: return f[6];
			5'd16: return !f[6];
			5'd17: return !f[3];
			5'd18: return f[7];
			default: return !f[7];
		endcase
	endfunction

	initial
	begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		sel = 4'h0;
		adr = 9'h000;
		dat_w = 32'h0;
		arst_n = 1'b0;
		bad_count = 0;
		tests_run = 0;
		repeat (4) @(posedge clk_sys);
		arst_n <= 1'b1;
		post(16'h0000, 8'h00);
		wb_rd(9'h010);
		check(rd, 32'h0, "unmapped read");
		wb_cycle(1'b1, `BBU_ADR_STATUS_REGISTER, 32'hff, 4'he);
		wb_rd(`BBU_ADR_STATUS_REGISTER);
		check(rd, 32'h0, "write without lane 0");
		$display("test bus done");
		// both k extremes, each wrapping the 16-bit counter
		for (int op = 1; op < 20; op++)
		begin
			for (int j = 0; j < 8; j++)
			begin
				sr0 = (j[2:1] == 0) ? 8'h00 : (j[2:1] == 1) ? 8'hff : (j[2:1] == 2) ? 8'h55 : 8'haa;
				k = j[0] ? 7'h40 : 7'h3f;
				pc0 = j[0] ? 16'h0010 : 16'hffe0;
				tk = cond(5'(op), 3'(j), sr0);
				pc_exp = tk ? pc0 + {{9{k[6]}}, k} + 16'h1 : pc0 + 16'h1;
				prep(pc0, sr0);
				run_op(5'(op), 3'(j), 5'd0, 1'b0, k, tk ? 2'd2 : 2'd1, tk);
				post(pc_exp, sr0);
			end
		end
		$display("test branches done");
		wb_cycle(1'b1, 9'h194, 32'h24, 4'hf);
		for (int c = 0; c < 3; c++)
		begin
			tk = (c != 2);
			prep(16'h1234, 8'h3c);
			run_op(5'd0, (c == 2) ? 3'd3 : 3'd2, 5'd5, c == 1, 7'h7f, tk ? 2'(c + 2) : 2'd1, tk);
			post(16'h1234 + (tk ? 16'(c + 2) : 16'h1), 8'h3c);
		end
		// a long skip, polled at once: status is served while the unit still runs
		wb_cycle(1'b1, `BBU_ADR_CMD, {18'h0, 1'b1, 5'd5, 3'd2, 5'd0}, 4'hf);
		wb_rd(`BBU_ADR_STAT);
		check(rd, 32'hf, "status poll while busy");
		$display("test skip done");
		wb_cycle(1'b1, 9'h1a4, 32'ha5, 4'hf);
		prep(16'h0100, 8'h96);
		run_op(5'd20, 3'd1, 5'd9, 1'b0, 7'h0, 2'd2, 1'b0);
		post(16'h0101, 8'h96);
		run_op(5'd21, 3'd7, 5'd9, 1'b0, 7'h0, 2'd2, 1'b0);
		wb_rd(9'h1a4);
		check(rd, 32'h27, "i/o bit set then clear");
		$display("test i/o bits done");
		for (int op = 22; op < 27; op++)
		begin
			for (int j = 0; j < 4; j++)
			begin
				v = (j == 0) ? 8'h80 : (j == 1) ? 8'h01 : (j == 2) ? 8'hc3 : 8'h00;
				sr0 = j[0] ? 8'hfe : 8'h31;
				case (op)
					22: sh = {v, 1'b0};
					23: sh = {v[0], 1'b0, v[7:1]};
					24: sh = {v, sr0[0]};
					25: sh = {v[0], sr0[0], v[7:1]};
					default: sh = {v[0], v[7], v[7:1]};
				endcase
				sr_exp = {sr0[7:4], sh[7] ^ sh[8], sh[7], sh[7:0] == 8'h00, sh[8]};
				wb_cycle(1'b1, 9'h10c, {24'h0, v}, 4'hf);
				prep(16'h0200, sr0);
				run_op(5'(op), 3'd0, 5'd3, 1'b0, 7'h0, 2'd1, 1'b0);
				post(16'h0201, sr_exp);
				wb_rd(9'h10c);
				check(rd, {24'h0, sh[7:0]}, "shift result");
			end
		end
		$display("test shifts done");
		v = 8'h5a;
		for (int s = 0; s < 8; s++)
		begin
			prep(16'h0300, 8'h00);
			run_op(5'd27, 3'(s), 5'd0, 1'b0, 7'h0, 2'd1, 1'b0);
			post(16'h0301, 8'h01 << s);
			prep(16'h0300, 8'hff);
			run_op(5'd28, 3'(s), 5'd0, 1'b0, 7'h0, 2'd1, 1'b0);
			post(16'h0301, ~(8'h01 << s));
			wb_cycle(1'b1, 9'h11c, {24'h0, v}, 4'hf);
			sr0 = v[s] ? 8'hbf : 8'h40;
			prep(16'h0300, sr0);
			run_op(5'd29, 3'(s), 5'd7, 1'b0, 7'h0, 2'd1, 1'b0);
			post(16'h0301, sr0 ^ 8'h40);
			sr0 = v[s] ? 8'h00 : 8'h40;
			prep(16'h0300, sr0);
			run_op(5'd30, 3'(s), 5'd7, 1'b0, 7'h0, 2'd1, 1'b0);
			post(16'h0301, sr0);
			wb_rd(9'h11c);
			check(rd, {24'h0, v ^ (8'h01 << s)}, "bit load result");
		end
		$display("test flag and bit transfer done");
		// code 31 is a no-op: one cycle, counter steps, flags kept
		prep(16'h0400, 8'h5a);
		run_op(5'd31, 3'd0, 5'd0, 1'b0, 7'h7f, 2'd1, 1'b0);
		post(16'h0401, 8'h5a);
		wb_rd(`BBU_ADR_CMD);
		check(rd, 32'h007f_001f, "command read-back");
		$display("test no-op done");
		arst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		post(16'h0000, 8'h00);
		wb_rd(`BBU_ADR_STAT);
		check(rd, 32'h0, "status after reset");
		wb_rd(`BBU_ADR_CMD);
		check(rd, 32'h0, "command after reset");
		$display("test reset done");
		end_sim();
	end
endmodule
`default_nettype wire
